// ### design/dar_ctrl.sv
// Contract
// - select code 100 reaches software word
// - reset code in software word resets all but readback
// - missed refresh while enabled raises alert
// - toggle bit copied into status bit
// - compensation bit selects internal or external
// - phase field sets channel clock alignment
// - frequency field picks divided switching clock
// - vmax field picks boost voltage limit
// - select code 000 reaches channel ramp register
// - ramp register holds enable, rate, step
// - ramp settings independent per channel
// - read frame returns addressed register contents; an unmapped address repeats the previous readback
`include "dar_defines.svh"

module dar_ctrl #(
    parameter int unsigned WD0_CYC = `DAR_WD0_US * `DAR_CLK_MHZ,
    parameter int unsigned WD1_CYC = `DAR_WD1_US * `DAR_CLK_MHZ,
    parameter int unsigned WD2_CYC = `DAR_WD2_US * `DAR_CLK_MHZ,
    parameter int unsigned WD3_CYC = `DAR_WD3_US * `DAR_CLK_MHZ
) (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    frame_valid,
    input  wire logic [`DAR_FRAME_W-1:0] frame_word,
    input  wire logic [1:0]              device_address,
    input  wire logic                    watchdog_enable,
    input  wire logic [1:0]              watchdog_select,
    output logic                         soft_reset,
    output logic                         alert,
    output logic                         status_user_toggle,
    output logic                         boost_comp_select,
    output logic [1:0]                   boost_phase_select,
    output logic [1:0]                   boost_freq_select,
    output logic [1:0]                   boost_vmax_select,
    output logic [3:0]                   ramp_enable,
    output logic [15:0]                  ramp_update_rate,
    output logic [11:0]                  ramp_step_size,
    output logic [15:0]                  readback_data,
    output logic                         readback_valid
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // frame decode
    // ----------------------------------------------------------------
    function automatic logic is_write(input logic [`DAR_FRAME_W-1:0] w, input logic [2:0] sel);
        is_write = !w[`DAR_RW_BIT] && (w[`DAR_SEL_HI:`DAR_SEL_LO] == sel);
    endfunction

    logic        mine;
    logic        wr_soft;
    logic        wr_boost;
    logic        wr_ramp;
    logic        rd_req;
    logic        do_reset;
    logic        do_refresh;
    logic [1:0]  ch;
    logic [15:0] data;

    assign mine       = frame_valid && (frame_word[`DAR_DEV_HI:`DAR_DEV_LO] == device_address);
    assign data       = frame_word[15:0];
    assign ch         = frame_word[`DAR_CH_HI:`DAR_CH_LO];
    assign wr_soft    = mine && is_write(frame_word, `DAR_SEL_SOFT);
    assign wr_boost   = mine && is_write(frame_word, `DAR_SEL_BOOST);
    assign wr_ramp    = mine && is_write(frame_word, `DAR_SEL_RAMP);
    assign rd_req     = mine && frame_word[`DAR_RW_BIT];
    assign do_reset   = wr_soft && (data[`DAR_CODE_HI:`DAR_CODE_LO] == `DAR_CODE_RESET);
    assign do_refresh = wr_soft && (data[`DAR_CODE_HI:`DAR_CODE_LO] == `DAR_CODE_REFRESH);

    // ----------------------------------------------------------------
    // software word, status toggle, boost control
    // ----------------------------------------------------------------
    logic       next_toggle;
    logic       next_comp;
    logic [1:0] next_phase;
    logic [1:0] next_freq;
    logic [1:0] next_vmax;

    always_comb begin
        next_toggle = status_user_toggle;
        next_comp   = boost_comp_select;
        next_phase  = boost_phase_select;
        next_freq   = boost_freq_select;
        next_vmax   = boost_vmax_select;
        if (do_reset) begin
            next_toggle = 1'b0;
            next_comp   = `DAR_COMP_RST;
            next_phase  = `DAR_PHASE_RST;
            next_freq   = `DAR_FREQ_RST;
            next_vmax   = `DAR_VMAX_RST;
        end else if (wr_soft) begin
            next_toggle = data[`DAR_TOGGLE_BIT];
        end else if (wr_boost) begin
            next_comp  = data[`DAR_COMP_BIT];
            next_phase = data[`DAR_PHASE_HI:`DAR_PHASE_LO];
            next_vmax  = data[`DAR_VMAX_HI:`DAR_VMAX_LO];
            if (data[`DAR_FREQ_HI:`DAR_FREQ_LO] != `DAR_FREQ_RSVD) begin
                next_freq = data[`DAR_FREQ_HI:`DAR_FREQ_LO];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_user_toggle <= 1'b0;
            boost_comp_select  <= `DAR_COMP_RST;
            boost_phase_select <= `DAR_PHASE_RST;
            boost_freq_select  <= `DAR_FREQ_RST;
            boost_vmax_select  <= `DAR_VMAX_RST;
            soft_reset         <= 1'b0;
        end else begin
            status_user_toggle <= next_toggle;
            boost_comp_select  <= next_comp;
            boost_phase_select <= next_phase;
            boost_freq_select  <= next_freq;
            boost_vmax_select  <= next_vmax;
            soft_reset         <= do_reset;
        end
    end

    // ----------------------------------------------------------------
    // per-channel ramp control
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic       next_en;
        logic [3:0] next_rate;
        logic [2:0] next_step;
        logic       hit;

        assign hit = wr_ramp && (ch == 2'(i));

        always_comb begin
            next_en   = ramp_enable[i];
            next_rate = ramp_update_rate[4*i+:4];
            next_step = ramp_step_size[3*i+:3];
            if (do_reset) begin
                next_en   = `DAR_RE_RST;
                next_rate = `DAR_RATE_RST;
                next_step = `DAR_STEP_RST;
            end else if (hit) begin
                next_en   = data[`DAR_RE_BIT];
                next_rate = data[`DAR_RATE_HI:`DAR_RATE_LO];
                next_step = data[`DAR_STEP_HI:`DAR_STEP_LO];
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                ramp_enable[i]          <= `DAR_RE_RST;
                ramp_update_rate[4*i+:4] <= `DAR_RATE_RST;
                ramp_step_size[3*i+:3]   <= `DAR_STEP_RST;
            end else begin
                ramp_enable[i]          <= next_en;
                ramp_update_rate[4*i+:4] <= next_rate;
                ramp_step_size[3*i+:3]   <= next_step;
            end
        end
    end

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    function automatic logic [`DAR_WD_CNT_W-1:0] wd_limit(input logic [1:0] s);
        case (s)
            2'h0:    wd_limit = `DAR_WD_CNT_W'(WD0_CYC - 1);
            2'h1:    wd_limit = `DAR_WD_CNT_W'(WD1_CYC - 1);
            2'h2:    wd_limit = `DAR_WD_CNT_W'(WD2_CYC - 1);
            default: wd_limit = `DAR_WD_CNT_W'(WD3_CYC - 1);
        endcase
    endfunction

    logic [`DAR_WD_CNT_W-1:0] wd_count;
    logic [`DAR_WD_CNT_W-1:0] next_wd_count;
    logic                     next_alert;
    logic                     wd_expire;

    assign wd_expire = watchdog_enable && (wd_count >= wd_limit(watchdog_select));

    always_comb begin
        next_wd_count = wd_count + `DAR_WD_CNT_W'(1);
        next_alert    = alert;
        if (!watchdog_enable || do_refresh || do_reset || wd_expire) begin
            next_wd_count = '0;
        end
        if (do_refresh || do_reset) begin
            next_alert = 1'b0;
        end
        if (wd_expire) begin
            next_alert = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_count <= '0;
            alert    <= 1'b0;
        end else begin
            wd_count <= next_wd_count;
            alert    <= next_alert;
        end
    end

    // ----------------------------------------------------------------
    // readback
    // ----------------------------------------------------------------
    logic [15:0]    next_rb_data;
    dar_pkg::dar_rd_t rd_kind;
    logic [4:0]     rda;

    assign rda = frame_word[`DAR_RDA_HI:`DAR_RDA_LO];

    always_comb begin
        rd_kind = dar_pkg::DAR_RD_NONE;
        if (rd_req) begin
            if (rda == `DAR_RDA_BOOST) begin
                rd_kind = dar_pkg::DAR_RD_BOOST;
            end else if (rda == `DAR_RDA_STATUS) begin
                rd_kind = dar_pkg::DAR_RD_STATUS;
            end else if (rda[4:2] == `DAR_RDA_RAMP) begin
                rd_kind = dar_pkg::DAR_RD_RAMP;
            end
        end
        next_rb_data = readback_data;
        case (rd_kind)
            dar_pkg::DAR_RD_BOOST: begin
                next_rb_data = {9'h000, boost_comp_select, boost_phase_select,
                                boost_freq_select, boost_vmax_select};
            end
            dar_pkg::DAR_RD_RAMP: begin
                next_rb_data = {3'h0, ramp_enable[rda[1:0]], 5'h00,
                                ramp_update_rate[4*rda[1:0]+:4], ramp_step_size[3*rda[1:0]+:3]};
            end
            dar_pkg::DAR_RD_STATUS: begin
                next_rb_data = {4'h0, status_user_toggle, 11'h000};
            end
            dar_pkg::DAR_RD_NONE: begin
                next_rb_data = readback_data;
            end
            default: begin
                next_rb_data = readback_data;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readback_data  <= 16'h0000;
            readback_valid <= 1'b0;
        end else begin
            readback_data  <= next_rb_data;
            readback_valid <= rd_req;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_soft_sel_only: assert property (wr_soft && !do_reset |=> $stable(boost_vmax_select)
                                      && $stable(ramp_enable)) else $error("software write touched controls");
    a_reset_defaults: assert property (do_reset |=> boost_freq_select == `DAR_FREQ_RST
                                       && ramp_enable == 4'h0 && soft_reset) else $error("reset code ignored");
    a_alert_cause: assert property ($rose(alert) |-> $past(watchdog_enable)) else $error("alert without watchdog");
    a_refresh_clear: assert property (do_refresh && !wd_expire |=> !alert ##1 wd_count <= 1) else $error("refresh");
    a_toggle_copy: assert property (wr_soft && !do_reset |=> status_user_toggle == $past(data[`DAR_TOGGLE_BIT]))
        else $error("toggle not mirrored");
    a_comp_phase: assert property (wr_boost |=> boost_comp_select == $past(data[`DAR_COMP_BIT])
                                   && boost_phase_select == $past(data[5:4])) else $error("boost write lost");
    a_freq_rsvd: assert property (wr_boost && data[3:2] == 2'h3 |=> $stable(boost_freq_select))
        else $error("reserved frequency taken");
    a_vmax_write: assert property (wr_boost |=> boost_vmax_select == $past(data[1:0])) else $error("vmax lost");
    a_ramp_isolate: assert property (wr_ramp && !do_reset |=> ramp_enable[$past(ch)] == $past(data[12])
                                     && $countones(ramp_enable ^ $past(ramp_enable)) <= 1) else $error("ramp write");
    a_read_status: assert property (rd_req && rda == 5'h18 |=> readback_valid
                                    && readback_data == {4'h0, $past(status_user_toggle), 11'h000}) else $error("readback");

endmodule

// ### design/dar_defines.svh
`ifndef DAR_DEFINES_SVH
`define DAR_DEFINES_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define DAR_FRAME_W        24
`define DAR_RW_BIT         23
`define DAR_DEV_HI         22
`define DAR_DEV_LO         21
`define DAR_RDA_HI         20
`define DAR_RDA_LO         16
`define DAR_CH_HI          17
`define DAR_CH_LO          16
`define DAR_SEL_HI         15
`define DAR_SEL_LO         13

// ----------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------
`define DAR_SEL_SOFT       3'h4
`define DAR_SEL_BOOST      3'h3
`define DAR_SEL_RAMP       3'h0

// ----------------------------------------------------------------
// software word fields and codes
// ----------------------------------------------------------------
`define DAR_TOGGLE_BIT     12
`define DAR_CODE_HI        11
`define DAR_CODE_LO        0
`define DAR_CODE_RESET     12'h0555
`define DAR_CODE_REFRESH   12'h0195
`define DAR_STAT_TOGGLE    11

// ----------------------------------------------------------------
// boost control fields and defaults
// ----------------------------------------------------------------
`define DAR_COMP_BIT       6
`define DAR_PHASE_HI       5
`define DAR_PHASE_LO       4
`define DAR_FREQ_HI        3
`define DAR_FREQ_LO        2
`define DAR_VMAX_HI        1
`define DAR_VMAX_LO        0
`define DAR_COMP_RST       1'h0
`define DAR_PHASE_RST      2'h0
`define DAR_FREQ_RST       2'h1
`define DAR_FREQ_RSVD      2'h3
`define DAR_VMAX_RST       2'h0

// ----------------------------------------------------------------
// ramp control fields and defaults
// ----------------------------------------------------------------
`define DAR_RE_BIT         12
`define DAR_RATE_HI        6
`define DAR_RATE_LO        3
`define DAR_STEP_HI        2
`define DAR_STEP_LO        0
`define DAR_RE_RST         1'h0
`define DAR_RATE_RST       4'h0
`define DAR_STEP_RST       3'h0

// ----------------------------------------------------------------
// readback addresses
// ----------------------------------------------------------------
`define DAR_RDA_RAMP       3'h5
`define DAR_RDA_STATUS     5'h18
`define DAR_RDA_BOOST      5'h1A

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DAR_CLK_MHZ        50
`define DAR_WD0_US         5000
`define DAR_WD1_US         10000
`define DAR_WD2_US         100000
`define DAR_WD3_US         200000
`define DAR_WD_CNT_W       24

`endif

// ### design/dar_pkg.sv
package dar_pkg;
    typedef enum logic [1:0] {
        DAR_RD_NONE,
        DAR_RD_BOOST,
        DAR_RD_RAMP,
        DAR_RD_STATUS
    } dar_rd_t;
endpackage

// ### dv/dar_host_model.sv
// ----------------------------------------------------------------
// host side: sends whole 24-bit frames, one valid cycle each
// ----------------------------------------------------------------
module dar_host_model #(
    parameter logic [1:0] DEV = 2'h1
) (
    input  wire logic        clk,
    output logic             frame_valid,
    output logic [23:0]      frame_word
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        frame_valid = 1'b0;
        frame_word  = 24'h00_0000;
    end

    task automatic raw(input logic [23:0] w);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame_word  <= w;
        @(posedge clk);
        frame_valid <= 1'b0;
        // released word shows no stale frame
        frame_word  <= ~w;
    endtask

    task automatic wr(input logic [2:0] sel, input logic [1:0] ch, input logic [12:0] d);
        raw({1'b0, DEV, 3'h0, ch, sel, d});
    endtask

    task automatic rd(input logic [4:0] rda);
        raw({1'b1, DEV, rda, 16'h0000});
    endtask
endmodule

// ### dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int WD[4] = '{20, 30, 40, 50};
    logic        clk, resetn, watchdog_enable, frame_valid;
    logic [1:0]  watchdog_select, device_address;
    logic [23:0] frame_word;
    logic        soft_reset, alert, status_user_toggle, boost_comp_select, readback_valid;
    logic [1:0]  boost_phase_select, boost_freq_select, boost_vmax_select, f;
    logic [3:0]  ramp_enable, re;
    logic [15:0] ramp_update_rate, readback_data, rt;
    logic [11:0] ramp_step_size, st;
    int          n_errors = 0, num_checks = 0, cyc = 0;

    dar_host_model #(.DEV(2'h1)) host (.clk(clk), .frame_valid(frame_valid), .frame_word(frame_word));
    dar_ctrl #(.WD0_CYC(20), .WD1_CYC(30), .WD2_CYC(40), .WD3_CYC(50)) DUT (
        .clk(clk), .resetn(resetn), .frame_valid(frame_valid), .frame_word(frame_word),
        .device_address(device_address), .watchdog_enable(watchdog_enable),
        .watchdog_select(watchdog_select), .soft_reset(soft_reset), .alert(alert),
        .status_user_toggle(status_user_toggle), .boost_comp_select(boost_comp_select),
        .boost_phase_select(boost_phase_select), .boost_freq_select(boost_freq_select),
        .boost_vmax_select(boost_vmax_select), .ramp_enable(ramp_enable),
        .ramp_update_rate(ramp_update_rate), .ramp_step_size(ramp_step_size),
        .readback_data(readback_data), .readback_valid(readback_valid));

    // ----------------------------------------------------------------
    // clock, timeout, checks, verdict
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    function automatic logic [15:0] boost();
        return {9'h000, boost_comp_select, boost_phase_select, boost_freq_select, boost_vmax_select};
    endfunction

    task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
        host.rd(a);
        #1;
        chk("rb_valid", 16'h0001, {15'h0000, readback_valid});
        chk("rb_data", e, readback_data);
    endtask

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        watchdog_enable = 1'b0;
        watchdog_select = 2'h0;
        device_address = 2'h1;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("boost_rst", 16'h0004, boost());
        f = 2'h1;
        for (int i = 0; i < 4; i++) begin
            host.wr(3'h3, 2'h0, {6'h00, i[0], i[1:0], i[1:0], i[1:0]});
            #1;
            if (i != 3) f = i[1:0];
            chk("boost", {9'h000, i[0], i[1:0], f, i[1:0]}, boost());
            rdchk(5'h1A, {9'h000, i[0], i[1:0], f, i[1:0]});
        end
        host.raw({1'b0, 2'h2, 5'h00, 3'h3, 13'h0000});
        #1;
        chk("other_addr", {9'h000, 1'b1, 2'h3, f, 2'h3}, boost());
        for (int c = 0; c < 4; c++) begin
            host.wr(3'h0, c[1:0], {~c[0], 5'h00, 4'(c + 9), 3'(c + 2)});
            re[c] = ~c[0];
            rt[4*c +: 4] = 4'(c + 9);
            st[3*c +: 3] = 3'(c + 2);
        end
        #1;
        chk("ramp_en", {12'h000, re}, {12'h000, ramp_enable});
        chk("ramp_rate", rt, ramp_update_rate);
        chk("ramp_step", {4'h0, st}, {4'h0, ramp_step_size});
        for (int c = 0; c < 4; c++) begin
            rdchk(5'h14 + 5'(c), {3'h0, re[c], 5'h00, rt[4*c +: 4], st[3*c +: 3]});
        end
        rdchk(5'h00, {3'h0, re[3], 5'h00, rt[15:12], st[11:9]});
        for (int t = 1; t >= 0; t--) begin
            host.wr(3'h4, 2'h0, {t[0], 12'h000});
            #1;
            chk("toggle", 16'(t), {15'h0000, status_user_toggle});
            rdchk(5'h18, {4'h0, t[0], 11'h000});
        end
        chk("alert_off", 16'h0000, {15'h0000, alert});
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            watchdog_enable <= 1'b1;
            watchdog_select <= 2'(s);
            host.wr(3'h4, 2'h0, 13'h0195);
            repeat (WD[s] / 2) @(posedge clk);
            host.wr(3'h4, 2'h0, 13'h0195);
            #1;
            chk("alert_clr", 16'h0000, {15'h0000, alert});
            repeat (WD[s] - 4) @(posedge clk);
            #1;
            chk("alert_early", 16'h0000, {15'h0000, alert});
            repeat (8) @(posedge clk);
            #1;
            chk("alert_set", 16'h0001, {15'h0000, alert});
        end
        host.wr(3'h4, 2'h0, 13'h1555);
        #1;
        chk("soft_reset", 16'h0001, {15'h0000, soft_reset});
        chk("alert_rst", 16'h0000, {15'h0000, alert});
        chk("boost_def", 16'h0004, boost());
        chk("ramp_def", 16'h0000, ramp_update_rate | {4'h0, ramp_step_size} | {12'h000, ramp_enable});
        chk("tog_def", 16'h0000, {15'h0000, status_user_toggle});
        stop_test();
    end
endmodule
